// *** pkg/fstr_defs.vh ***
// Constants for the front-end switch register bank.
// Assumes inclusion by bare name from the design file.
// Behaviour
// - Control bit 7 set selects low-power operation, clear selects normal; resets 0.
// - Writing control bit 6 as 1 resets every register to default.
// - Masked trigger: writes to its registers reach destination at once.
// - All three triggers unmasked: writes go to shadow; destination holds until trigger.
// - Trigger strobe 1 copies shadow into destination if unmasked; write-only.
// - All trigger masks are 0 after reset.
// - Address 0x1D reads a fixed 8-bit part number.
// - Address 0x1E reads the low eight maker identification bits.
// - Writes to maker identification registers complete without changing them.
// - Address 0x1F bits 5:4 read maker bits 9:8; bits 7:6 read 00.
// - Address 0x1F bits 3:0 hold writable slave identifier, default 1011.
// - Register 0 resets to zero, read/write, served by triggers 0-2.
// - Frame: slave in C[11:8]; write 010, read 011, register-0 write C7=1.
`ifndef FSTR_DEFS_VH
`define FSTR_DEFS_VH
`define FSTR_ADDR_SWITCH 5'h00
`define FSTR_ADDR_CTRL 5'h1c
`define FSTR_ADDR_PART 5'h1d
`define FSTR_ADDR_MAKLO 5'h1e
`define FSTR_ADDR_MAKHI 5'h1f
`define FSTR_SWITCH_RST 8'h00
`define FSTR_SLAVE_RST 4'hb
`define FSTR_BIT_LOWPWR 7
`define FSTR_BIT_STARTUP 6
`define FSTR_MASK_HI 5
`define FSTR_MASK_LO 3
`define FSTR_TRIG_HI 2
`define FSTR_TRIG_LO 0
`define FSTR_CMD_W 3'h2
`define FSTR_CMD_R 3'h3
`define FSTR_BROADCAST 4'h0
`define FSTR_SSC_LEN 4'h3
`define FSTR_CMD_BITS 4'hc
`define FSTR_DATA_BITS 4'h9
`endif

// *** logic/fstr_regs.v ***
// Register bank and two-wire link slave of the front-end antenna switch.
// Assumes the master drives sclk and sdata; sdata is shared and turned round by the master.
`timescale 1ns/1ps
`include "fstr_defs.vh"
module fstr_regs #(
  parameter [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter [9:0] MAKER_ID = 10'h155 // Arbitrary value
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Link pins
  input wire sclkIn,
  input wire sdataIn,
  output reg sdataOut,
  output reg sdataOe,
  // Device state
  output reg lowPower,
  output reg [7:0] switchPath
);
  // ************************
  // Reset and input sync
  // ************************
  reg rstA;
  reg rstB;
  wire rstN = rstB;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstA <= 1'b0;
      rstB <= 1'b0;
    end
    else
    begin
      rstA <= 1'b1;
      rstB <= rstA;
    end
  end
  reg [1:0] sclkSync;
  reg [1:0] sdataSync;
  reg sclkLast;
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sclkSync <= 2'b00;
      sdataSync <= 2'b00;
      sclkLast <= 1'b0;
    end
    else
    begin
      sclkSync <= {sclkSync[0], sclkIn};
      sdataSync <= {sdataSync[0], sdataIn};
      sclkLast <= sclkSync[1];
    end
  end
  wire sclk = sclkSync[1];
  wire sdat = sdataSync[1];
  wire rise = sclk & ~sclkLast;
  wire fall = ~sclk & sclkLast;
  // ************************
  // Frame receiver
  // ************************
  localparam ST_IDLE = 5'h01;
  localparam ST_CMD = 5'h02;
  localparam ST_DATA = 5'h04;
  localparam ST_RD = 5'h08;
  localparam ST_PARK = 5'h10;
  reg [4:0] state;
  reg [3:0] cnt;
  reg [12:0] cmd;
  reg [8:0] shift;
  reg [8:0] rdShift;
  reg sdatLast;
  reg sscSeen;
  reg sscArm;
  reg wrPend;
  // Sequence start: data pulses high then low with no clock rise between
  wire sdatFall = sdatLast & ~sdat;
  wire sdatRise = ~sdatLast & sdat;
  wire [4:0] cmdAddr = cmd[5:1];
  reg wrStb;
  reg [4:0] wrAddr;
  reg [7:0] wrData;
  // ************************
  // Registers
  // ************************
  reg [3:0] slaveId;
  reg [2:0] trigMask;
  reg [7:0] shadow;
  reg startupPend;
  wire [2:0] trigHit = wrData[`FSTR_TRIG_HI:`FSTR_TRIG_LO] & ~trigMask;
  wire ctrlWr = wrStb && (wrAddr == `FSTR_ADDR_CTRL);
  reg [7:0] rdData;
  always @*
  begin
    case (cmdAddr)
      `FSTR_ADDR_SWITCH: rdData = switchPath;
      // Trigger strobes read back as zero
      `FSTR_ADDR_CTRL: rdData = {lowPower, 1'b0, trigMask, 3'h0};
      `FSTR_ADDR_PART: rdData = PART_ID;
      `FSTR_ADDR_MAKLO: rdData = MAKER_ID[7:0];
      `FSTR_ADDR_MAKHI: rdData = {2'b00, MAKER_ID[9:8], slaveId};
      default: rdData = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      cmd <= 13'h0;
      shift <= 9'h0;
      rdShift <= 9'h0;
      sdatLast <= 1'b0;
      sscArm <= 1'b0;
      wrPend <= 1'b0;
      sscSeen <= 1'b0;
      wrStb <= 1'b0;
      wrAddr <= 5'h0;
      wrData <= 8'h0;
      sdataOut <= 1'b0;
      sdataOe <= 1'b0;
    end
    else
    begin
      sdatLast <= sdat;
      wrStb <= 1'b0;
      // Data bits change before their clock rise, so only a pulse with no rise inside is a start
      if (rise)
        sscArm <= 1'b0;
      else if (!sclk && sdatRise)
        sscArm <= 1'b1;
      if (!sclk && sdatFall && sscArm && state == ST_IDLE)
        sscSeen <= 1'b1;
      case (state)
        ST_IDLE:
          if (sscSeen && rise)
          begin
            // Fold the first command bit in with this edge
            cmd <= {12'h0, sdat};
            cnt <= 4'h1;
            sscSeen <= 1'b0;
            state <= ST_CMD;
          end
        ST_CMD:
          if (rise)
          begin
            cmd <= {cmd[11:0], sdat};
            cnt <= cnt + 4'h1;
            if (cnt == `FSTR_CMD_BITS)
            begin
              cnt <= 4'h0;
              if (!(^{cmd[11:0], sdat}) || !((cmd[11:8] == slaveId) ||
                  (cmd[11:8] == `FSTR_BROADCAST && cmd[7:5] == `FSTR_CMD_W)))
                state <= ST_IDLE;
              else if (cmd[7])
              begin
                // Register-0 write carries seven bits; it lands once the park bit ends
                wrPend <= 1'b1;
                wrAddr <= `FSTR_ADDR_SWITCH;
                wrData <= {1'b0, cmd[6:0]};
                // Nonzero count makes the park state wait for the park bit's rise
                cnt <= 4'h1;
                state <= ST_PARK;
              end
              else if (cmd[7:5] == `FSTR_CMD_R)
                state <= ST_RD;
              else if (cmd[7:5] == `FSTR_CMD_W)
                state <= ST_DATA;
              else
                state <= ST_IDLE;
            end
          end
        ST_DATA:
          if (rise)
          begin
            shift <= {shift[7:0], sdat};
            cnt <= cnt + 4'h1;
            if (cnt == `FSTR_DATA_BITS - 4'h1)
            begin
              wrPend <= ^{shift[7:0], sdat};
              wrAddr <= cmdAddr;
              wrData <= shift[7:0];
              state <= ST_PARK;
            end
          end
        ST_RD:
          // One bus-park bit, then eight data bits plus odd parity on rising edges
          if (rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0)
            begin
              sdataOe <= 1'b1;
              sdataOut <= rdData[7];
              rdShift <= {rdData[6:0], ~^rdData, 1'b0};
            end
            else if (cnt == `FSTR_DATA_BITS)
            begin
              cnt <= 4'h0;
              sdataOut <= 1'b0;
              state <= ST_PARK;
            end
            else
            begin
              sdataOut <= rdShift[8];
              rdShift <= {rdShift[7:0], 1'b0};
            end
          end
        ST_PARK:
          // Reads leave on the next fall; writes wait for the park bit's rise first
          if (rise)
            cnt <= 4'h0;
          else if (fall && cnt == 4'h0)
          begin
            wrStb <= wrPend;
            wrPend <= 1'b0;
            sdataOe <= 1'b0;
            state <= ST_IDLE;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      lowPower <= 1'b0;
      trigMask <= 3'h0;
      slaveId <= `FSTR_SLAVE_RST;
      switchPath <= `FSTR_SWITCH_RST;
      shadow <= `FSTR_SWITCH_RST;
      startupPend <= 1'b0;
    end
    else if (startupPend)
    begin
      // Startup bit never stores, so it reads 0 once defaults are back
      lowPower <= 1'b0;
      trigMask <= 3'h0;
      slaveId <= `FSTR_SLAVE_RST;
      switchPath <= `FSTR_SWITCH_RST;
      shadow <= `FSTR_SWITCH_RST;
      startupPend <= 1'b0;
    end
    else if (wrStb)
    begin
      case (wrAddr)
        `FSTR_ADDR_SWITCH:
        begin
          shadow <= wrData;
          // All three triggers serve this register; any masked one passes the write
          if (|trigMask)
            switchPath <= wrData;
        end
        `FSTR_ADDR_CTRL:
        begin
          lowPower <= wrData[`FSTR_BIT_LOWPWR];
          startupPend <= wrData[`FSTR_BIT_STARTUP];
          trigMask <= wrData[`FSTR_MASK_HI:`FSTR_MASK_LO];
          if (|trigHit)
            switchPath <= shadow;
        end
        `FSTR_ADDR_MAKHI: slaveId <= wrData[3:0];
        default: slaveId <= slaveId;
      endcase
    end
  end
endmodule

// *** test/fstr_regs_asserts.sv ***
// Port checker for the switch register bank.
// Assumes it is bound to each fstr_regs instance.
`timescale 1ns/1ps
module fstr_regs_asserts (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Link and state
  input wire sclkIn,
  input wire sdataIn,
  input wire sdataOut,
  input wire sdataOe,
  input wire lowPower,
  input wire [7:0] switchPath
);
  // ****
  // Properties
  // ****
  reg [7:0] oeCnt;
  always @(posedge clk or negedge nrst)
    if (!nrst)
      oeCnt <= 8'h00;
    else
      oeCnt <= sdataOe ? oeCnt + 8'h01 : 8'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RST: assert property (disable iff (1'b0) !nrst |-> !sdataOe && !lowPower && switchPath == 8'h00)
    else $error("outputs not cleared in reset");
  AST_REL: assert property ($rose(nrst) |-> (!lowPower && switchPath == 8'h00)[*3])
    else $error("outputs moved after reset release");
  AST_SW: assert property ($changed(switchPath) |-> !sclkIn && !$past(sclkIn))
    else $error("switch path moved inside a frame");
  AST_LP: assert property ($changed(lowPower) |-> !sclkIn && !$past(sclkIn))
    else $error("low power moved inside a frame");
  AST_RDHOLD: assert property (sdataOe |-> $stable(switchPath) && $stable(lowPower))
    else $error("state moved during a read");
  AST_OEFALL: assert property ($fell(sdataOe) |-> !sclkIn && !$past(sdataOut))
    else $error("bad data line release");
  AST_OEMIN: assert property ($rose(sdataOe) |-> sdataOe[*8])
    else $error("read drive too short");
  AST_OEMAX: assert property (oeCnt <= 8'h64)
    else $error("read drive too long");
  cover property ($rose(sdataOe));
  cover property ($changed(switchPath));
  cover property ($rose(lowPower));
endmodule
bind fstr_regs fstr_regs_asserts uChk (.clk(clk), .nrst(nrst), .sclkIn(sclkIn), .sdataIn(sdataIn),
  .sdataOut(sdataOut), .sdataOe(sdataOe), .lowPower(lowPower), .switchPath(switchPath));

// *** test/fstr_master.sv ***
// Link master model driving clock and data.
// Assumes a 50 ns clk; one link bit is eight clk cycles.
`timescale 1ns/1ps
module fstr_master (
  // Clock
  input wire clk,
  // Device side
  input wire devOut,
  input wire devOe,
  // Link lines
  output reg sclk,
  output wire sdata
);
  reg mOut = 1'b0;
  reg mOe = 1'b1;
  reg last = 1'b0;
  initial sclk = 1'b0;
  // Released line shows the inverse of its last level
  assign sdata = devOe ? devOut : (mOe ? mOut : ~last);
  always @(posedge clk)
    if (devOe || mOe)
      last <= sdata;
  task cyc(input b, input oe, output r);
  begin
    @(posedge clk);
    mOut <= b;
    mOe <= oe;
    repeat (3) @(posedge clk);
    r = sdata;
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
  end
  endtask
  task xfer(input [21:0] f, input integer n, input rd, output [8:0] q);
    integer i;
    reg r;
  begin
    q = 9'h000;
    @(posedge clk);
    mOut <= 1'b1;
    repeat (4) @(posedge clk);
    mOut <= 1'b0;
    for (i = 0; i < n; i = i + 1)
      cyc(f[n - 1 - i], 1'b1, r);
    if (rd)
      for (i = 14; i < 25; i = i + 1)
      begin
        cyc(1'b0, 1'b0, r);
        // First data bit shows one bit after the park rise
        if (i >= 15 && i < 24)
          q = {q[7:0], r};
      end
    else
      cyc(1'b0, 1'b1, r);
    // Retake the idle line at once so no false start shows
    mOe <= 1'b1;
    mOut <= 1'b0;
    repeat (8) @(posedge clk);
  end
  endtask
endmodule

// *** test/tb_frontend_slave_trigger_regs.sv ***
// Self-checking bench for the switch register bank.
// Assumes fstr_regs and the link master model.
`timescale 1ns/1ps
module tb_frontend_slave_trigger_regs;
  localparam [7:0] PART = 8'h3c; // Arbitrary value
  localparam [9:0] MAKER = 10'h2a7; // Arbitrary value
  reg clk = 1'b0;
  reg nrst = 1'b0;
  wire sclk, sdata, sdataOut, sdataOe, lowPower;
  wire [7:0] switchPath;
  reg [8:0] q;
  integer nErrors = 0, checks = 0, cycles = 0, seed = 35479, k;
  integer sw = 0, sh = 0, msk = 0, lp = 0, sid = 11;
  initial forever #25 clk = ~clk;
  fstr_regs #(.PART_ID(PART), .MAKER_ID(MAKER)) uut (.clk(clk), .nrst(nrst), .sclkIn(sclk),
    .sdataIn(sdata), .sdataOut(sdataOut), .sdataOe(sdataOe), .lowPower(lowPower), .switchPath(switchPath));
  fstr_master master (.clk(clk), .devOut(sdataOut), .devOe(sdataOe), .sclk(sclk), .sdata(sdata));
  // ****
  // Model and tasks
  // ****
  function [7:0] mrd(input [4:0] a);
    case (a)
      5'h00: mrd = sw;
      5'h1c: mrd = {lp[0], 1'b0, msk[2:0], 3'b000};
      5'h1d: mrd = PART;
      5'h1e: mrd = MAKER[7:0];
      default: mrd = {2'b00, MAKER[9:8], sid[3:0]};
    endcase
  endfunction
  task cmp(input [8:0] e, input [8:0] s, input [63:0] what);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      nErrors = nErrors + 1;
      $display("wrong value %0s expected %h seen %h", what, e, s);
    end
  end
  endtask
  task finishTest;
  begin
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // Mode 1 spoils command parity, mode 3 data parity, mode 2 sends the short register 0 write
  task wr(input [3:0] sa, input [4:0] a, input [7:0] d, input [1:0] mode);
    reg [11:0] c;
  begin
    c = mode == 2 ? {sa, 1'b1, d[6:0]} : {sa, 3'b010, a};
    master.xfer(mode == 2 ? {9'h000, c, ~^c} : {c, ~^c ^ (mode == 1), d, ~^d ^ (mode == 3)},
      mode == 2 ? 13 : 22, 1'b0, q);
    if (mode == 2)
      d[7] = 1'b0;
    if (!mode[0] && (sa == sid || sa == 4'h0))
    begin
      if (a == 5'h00)
        sh = d;
      if (a == 5'h00 && msk != 0)
        sw = d;
      if (a == 5'h1c && d[6])
      begin
        sw = 0;
        sh = 0;
        msk = 0;
        lp = 0;
        sid = 11;
      end
      else if (a == 5'h1c)
      begin
        if (d[2:0] & ~msk)
          sw = sh;
        lp = d[7];
        msk = d[5:3];
      end
      if (a == 5'h1f)
        sid = d[3:0];
    end
    repeat (4) @(posedge clk);
    cmp({lp[0], sw[7:0]}, {lowPower, switchPath}, "outputs");
  end
  endtask
  task rd(input [4:0] a);
    reg [11:0] c;
  begin
    c = {sid[3:0], 3'b011, a};
    master.xfer({9'h000, c, ~^c}, 13, 1'b1, q);
    cmp({mrd(a), ~^mrd(a)}, q, "read");
  end
  endtask
  task rdAll;
    integer j;
    for (j = 0; j < 5; j = j + 1)
      rd(j == 0 ? 0 : j + 27);
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      nErrors = nErrors + 1;
      finishTest;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rdAll;
    for (k = 0; k < 3; k = k + 1)
    begin
      wr(sid, 0, $random(seed), 0);
      wr(sid, 5'h1c, 8'h01 << k, 0);
    end
    wr(sid, 0, $random(seed), 2);
    wr(sid, 5'h1c, 8'h02, 0);
    $display("test shadow done");
    wr(sid, 5'h1c, 8'hb8, 0);
    wr(sid, 0, $random(seed), 0);
    rdAll;
    wr(sid, 5'h1c, 8'h00, 0);
    $display("test mask done");
    for (k = 0; k < 3; k = k + 1)
      wr(sid, 5'h1d + k, $random(seed) | 8'h01, 0);
    rdAll;
    wr(sid ^ 1, 0, $random(seed), 0);
    wr(sid, 0, $random(seed), 1);
    wr(sid, 5'h1c, 8'h80, 3);
    wr(4'h0, 0, $random(seed), 0);
    wr(sid, 5'h1c, 8'h07, 0);
    $display("test id done");
    for (k = 0; k < 9; k = k + 1)
    begin
      wr(sid, k % 3 == 0 ? 0 : 5'h1c + (k % 3 - 1) * 3, $random(seed) & 8'hbf | 8'h01, 0);
      rd(5'h1c);
    end
    wr(sid, 5'h1c, $random(seed) | 8'h40, 0);
    rdAll;
    $display("test startup done");
    finishTest;
  end
endmodule
